/* File: design/dsg_instr_gen.sv */
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dsg_regs.svh"

// How it works
// (R1) Word width is 15, 20 or 22 bits per variant, upper bits zero.
// (R2) The word packs sources, carry and mode bits, alu code at 10..7.
// (R3) Bits 3..0 pick XY: zero, output, A:B, A*B, C, output+C or A:B+C.
// (R4) In the concatenated source A is the upper part and B the lower part.
// (R5) Bits 6..4 pick Z: zero, cascade, output, C or either one shifted.
// (R6) The shifted Z sources are cascade or output shifted right by 17.
// (R7) The full variant carries W: zero, output, rounding constant or C.
// (R8) Carry is 0, 1, the pin, four roundings, two wide modes or A*B round.
// (R9) Custom fields except W act only under the custom select, else a preset rules.
// (R10) Presets: C+A*B, cascade+A*B, output+A*B, A*B, C+A:B, C-A:B and C.
// (R11) The full variant picks A or B as the pre-adder partner of D.
// (R12) Full variant: A or the pre-adder sum feeds the 27-bit multiplier A.
// (R13) Full variant: B or the pre-adder sum feeds the 18-bit multiplier B.
// (R14) The full variant carries the A stage choice, first or second.
// (R15) The middle and full variants carry the B stage, first or second.
// (R16) The output is a constant word that an outside mux may sequence.
// (R17) The word depends on static configuration and, with the pin carry selected, the synchronised carry pin.
module dsg_instr_gen
(
    input  wire logic                   ref_clk,
    input  wire logic                   arst_n,
    input  wire logic [2:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   carry_in,
    output logic [21:0]                 instr_word,
    output logic [4:0]                  instr_width,
    output logic                        instr_illegal
);
    import dsg_pkg::*;

    dsg_state_t s_reg;
    dsg_state_t s_next;
    logic [21:0] enc_word;
    logic [4:0]  enc_width;
    logic        enc_illegal;
    logic        wr_take;
    logic        rd_take;

    dsg_instr_encode u_encode
    (
        .variant    (s_reg.variant_reg),
        .opsel      (s_reg.opsel_reg),
        .xy         (s_reg.xy_reg),
        .z          (s_reg.z_reg),
        .alu        (s_reg.alu_reg),
        .carry      (s_reg.carry_reg),
        .w          (s_reg.w_reg),
        .paf        (s_reg.paf_reg),
        .pas        (s_reg.pas_reg),
        .mas        (s_reg.mas_reg),
        .mbs        (s_reg.mbs_reg),
        .ast        (s_reg.ast_reg),
        .bst        (s_reg.bst_reg),
        .cin_ext    (s_reg.cin_sync_reg),
        .word       (enc_word),
        .width      (enc_width),
        .illegal    (enc_illegal)
    );

    // one wait cycle per access: the write lands and read data stand at
    // the edge where waitrequest is seen low
    assign wr_take = avs_write & ~s_reg.waitreq_reg;
    assign rd_take = avs_read & s_reg.waitreq_reg;

    always_comb
    begin
        s_next = s_reg;
        s_next.cin_meta_reg = carry_in;
        s_next.cin_sync_reg = s_reg.cin_meta_reg;
        s_next.waitreq_reg  = ~((avs_read | avs_write) & s_reg.waitreq_reg);

        if (wr_take)
        begin
            case (avs_address)
                `DSG_ADDR_CTRL:
                begin
                    s_next.variant_reg = dsg_variant_t'(
                        avs_writedata[`DSG_CTRL_VAR_MSB:`DSG_CTRL_VAR_LSB]);
                    s_next.opsel_reg = dsg_opsel_t'(
                        avs_writedata[`DSG_CTRL_OPS_MSB:`DSG_CTRL_OPS_LSB]);
                end
                `DSG_ADDR_CUSTOM:
                begin
                    s_next.xy_reg =
                        avs_writedata[`DSG_CUS_XY_MSB:`DSG_CUS_XY_LSB];
                    s_next.z_reg =
                        avs_writedata[`DSG_CUS_Z_MSB:`DSG_CUS_Z_LSB];
                    s_next.alu_reg =
                        avs_writedata[`DSG_CUS_ALU_MSB:`DSG_CUS_ALU_LSB];
                    s_next.carry_reg =
                        avs_writedata[`DSG_CUS_CRY_MSB:`DSG_CUS_CRY_LSB];
                    s_next.w_reg =
                        avs_writedata[`DSG_CUS_W_MSB:`DSG_CUS_W_LSB];
                end
                `DSG_ADDR_SLICE:
                begin
                    s_next.paf_reg =
                        avs_writedata[`DSG_SLC_PAF_MSB:`DSG_SLC_PAF_LSB];
                    s_next.pas_reg = avs_writedata[`DSG_SLC_PAS_BIT];
                    s_next.mas_reg = avs_writedata[`DSG_SLC_MAS_BIT];
                    s_next.mbs_reg = avs_writedata[`DSG_SLC_MBS_BIT];
                    s_next.ast_reg = avs_writedata[`DSG_SLC_AST_BIT];
                    s_next.bst_reg = avs_writedata[`DSG_SLC_BST_BIT];
                end
                default:
                    s_next.waitreq_reg = 1'b1;
            endcase
        end

        if (rd_take)
        begin
            s_next.rdata_reg = '0;
            case (avs_address)
                `DSG_ADDR_CTRL:
                begin
                    s_next.rdata_reg[`DSG_CTRL_VAR_MSB:`DSG_CTRL_VAR_LSB] =
                        s_reg.variant_reg;
                    s_next.rdata_reg[`DSG_CTRL_OPS_MSB:`DSG_CTRL_OPS_LSB] =
                        s_reg.opsel_reg;
                end
                `DSG_ADDR_CUSTOM:
                begin
                    s_next.rdata_reg[`DSG_CUS_XY_MSB:`DSG_CUS_XY_LSB] =
                        s_reg.xy_reg;
                    s_next.rdata_reg[`DSG_CUS_Z_MSB:`DSG_CUS_Z_LSB] =
                        s_reg.z_reg;
                    s_next.rdata_reg[`DSG_CUS_ALU_MSB:`DSG_CUS_ALU_LSB] =
                        s_reg.alu_reg;
                    s_next.rdata_reg[`DSG_CUS_CRY_MSB:`DSG_CUS_CRY_LSB] =
                        s_reg.carry_reg;
                    s_next.rdata_reg[`DSG_CUS_W_MSB:`DSG_CUS_W_LSB] =
                        s_reg.w_reg;
                end
                `DSG_ADDR_SLICE:
                begin
                    s_next.rdata_reg[`DSG_SLC_PAF_MSB:`DSG_SLC_PAF_LSB] =
                        s_reg.paf_reg;
                    s_next.rdata_reg[`DSG_SLC_PAS_BIT] = s_reg.pas_reg;
                    s_next.rdata_reg[`DSG_SLC_MAS_BIT] = s_reg.mas_reg;
                    s_next.rdata_reg[`DSG_SLC_MBS_BIT] = s_reg.mbs_reg;
                    s_next.rdata_reg[`DSG_SLC_AST_BIT] = s_reg.ast_reg;
                    s_next.rdata_reg[`DSG_SLC_BST_BIT] = s_reg.bst_reg;
                end
                `DSG_ADDR_INSTR:
                    s_next.rdata_reg = 32'(s_reg.instr_reg);
                `DSG_ADDR_STATUS:
                begin
                    s_next.rdata_reg[`DSG_STS_ILL_BIT] = s_reg.illegal_reg;
                    s_next.rdata_reg[`DSG_STS_WID_MSB:`DSG_STS_WID_LSB] =
                        s_reg.width_reg;
                end
                default:
                    s_next.rdata_reg = '0;
            endcase
        end

        // the encoder output is registered so the slice sees a clean
        // word; it only moves after reset, a configuration write or a change
        // of the synchronised carry pin when that pin is selected
        s_next.instr_reg   = enc_word; // (R1) (R16) (R17)
        s_next.width_reg   = enc_width; // (R1)
        s_next.illegal_reg = enc_illegal;
    end

    // field coverage of the encoder, kept here for the reader:
    // alu code and carry bit at fixed positions (R2)
    // XY codes incl. A:B, A upper and B lower (R3) (R4)
    // Z codes incl. the 17-bit arithmetic downshift sources (R5) (R6)
    // W source in the full variant (R7)
    // carry choices with the synchronised pin (R8)
    // presets versus custom fields (R9) (R10)
    // pre-adder and multiplier port selects, stage choices (R11) (R12)
    // (R13) (R14) (R15)

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_reg.variant_reg  <= DSG_VAR_BASE;
            s_reg.opsel_reg    <= dsg_opsel_t'(`DSG_RST_CTRL_OPS);
            s_reg.xy_reg       <= DSG_XY_ZERO;
            s_reg.z_reg        <= DSG_Z_ZERO;
            s_reg.alu_reg      <= `DSG_ALU_ADD;
            s_reg.carry_reg    <= DSG_CY_ZERO;
            s_reg.w_reg        <= DSG_W_ZERO;
            s_reg.paf_reg      <= `DSG_RST_PAF;
            s_reg.pas_reg      <= 1'b0;
            s_reg.mas_reg      <= 1'b0;
            s_reg.mbs_reg      <= 1'b0;
            s_reg.ast_reg      <= 1'b0;
            s_reg.bst_reg      <= 1'b0;
            s_reg.cin_meta_reg <= 1'b0;
            s_reg.cin_sync_reg <= 1'b0;
            s_reg.instr_reg    <= '0;
            s_reg.width_reg    <= `DSG_WIDTH_BASE;
            s_reg.illegal_reg  <= 1'b0;
            s_reg.waitreq_reg  <= 1'b1;
            s_reg.rdata_reg    <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata    = s_reg.rdata_reg;
    assign avs_waitrequest = s_reg.waitreq_reg;
    assign instr_word      = s_reg.instr_reg;
    assign instr_width     = s_reg.width_reg;
    assign instr_illegal   = s_reg.illegal_reg;

endmodule

`default_nettype wire

/* File: design/dsg_regs.svh */
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

// avalon word addresses
`define DSG_ADDR_W          3
`define DSG_ADDR_CTRL       3'h0
`define DSG_ADDR_CUSTOM     3'h1
`define DSG_ADDR_SLICE      3'h2
`define DSG_ADDR_INSTR      3'h3
`define DSG_ADDR_STATUS     3'h4

// control register fields
`define DSG_CTRL_VAR_MSB    1
`define DSG_CTRL_VAR_LSB    0
`define DSG_CTRL_OPS_MSB    6
`define DSG_CTRL_OPS_LSB    4

// custom register fields
`define DSG_CUS_XY_MSB      3
`define DSG_CUS_XY_LSB      0
`define DSG_CUS_Z_MSB       6
`define DSG_CUS_Z_LSB       4
`define DSG_CUS_ALU_MSB     11
`define DSG_CUS_ALU_LSB     8
`define DSG_CUS_CRY_MSB     15
`define DSG_CUS_CRY_LSB     12
`define DSG_CUS_W_MSB       17
`define DSG_CUS_W_LSB       16

// slice configuration register fields
`define DSG_SLC_PAF_MSB     3
`define DSG_SLC_PAF_LSB     0
`define DSG_SLC_PAS_BIT     4
`define DSG_SLC_MAS_BIT     5
`define DSG_SLC_MBS_BIT     6
`define DSG_SLC_AST_BIT     7
`define DSG_SLC_BST_BIT     8

// status register fields
`define DSG_STS_ILL_BIT     0
`define DSG_STS_WID_MSB     12
`define DSG_STS_WID_LSB     8

// instruction word layout
`define DSG_INSTR_W         22
`define DSG_IW_XY_MSB       3
`define DSG_IW_XY_LSB       0
`define DSG_IW_Z_MSB        6
`define DSG_IW_Z_LSB        4
`define DSG_IW_ALU_MSB      10
`define DSG_IW_ALU_LSB      7
`define DSG_IW_CIN_BIT      11
`define DSG_IW_CSEL_MSB     14
`define DSG_IW_CSEL_LSB     12
`define DSG_IW_E1PA_MSB     18
`define DSG_IW_E1PA_LSB     15
`define DSG_IW_E1BS_BIT     19
`define DSG_IW_W_MSB        16
`define DSG_IW_W_LSB        15
`define DSG_IW_PAS_BIT      17
`define DSG_IW_MAS_BIT      18
`define DSG_IW_MBS_BIT      19
`define DSG_IW_AST_BIT      20
`define DSG_IW_BST_BIT      21

// word widths per variant
`define DSG_WIDTH_BASE      5'h0f
`define DSG_WIDTH_MID       5'h14
`define DSG_WIDTH_FULL      5'h16

// alu function codes
`define DSG_ALU_ADD         4'h0
`define DSG_ALU_SUB         4'h3

// carry codes from code 3 upward map onto select code minus this base
`define DSG_CSEL_BASE       4'h2
`define DSG_CSEL_FABRIC     3'h0

// reset values
`define DSG_RST_CTRL_OPS    3'h0
`define DSG_RST_PAF         4'h0

`endif

/* File: design/dsg_pkg.sv */
package dsg_pkg;

    typedef enum logic [1:0] {
        DSG_VAR_BASE = 2'b00,
        DSG_VAR_MID  = 2'b01,
        DSG_VAR_FULL = 2'b10,
        DSG_VAR_RSVD = 2'b11
    } dsg_variant_t;

    typedef enum logic [2:0] {
        DSG_OP_C_AB_MUL   = 3'b000,
        DSG_OP_CAS_AB_MUL = 3'b001,
        DSG_OP_P_AB_MUL   = 3'b010,
        DSG_OP_AB_MUL     = 3'b011,
        DSG_OP_C_ADD_CAT  = 3'b100,
        DSG_OP_C_SUB_CAT  = 3'b101,
        DSG_OP_C_ONLY     = 3'b110,
        DSG_OP_CUSTOM     = 3'b111
    } dsg_opsel_t;

    typedef enum logic [3:0] {
        DSG_XY_ZERO     = 4'b0000,
        DSG_XY_P        = 4'b0001,
        DSG_XY_CAT      = 4'b0010,
        DSG_XY_MUL      = 4'b0011,
        DSG_XY_C        = 4'b0100,
        DSG_XY_P_PLUS_C = 4'b0101,
        DSG_XY_CAT_C    = 4'b0110
    } dsg_xy_t;

    typedef enum logic [2:0] {
        DSG_Z_ZERO    = 3'b000,
        DSG_Z_CASCADE = 3'b001,
        DSG_Z_P       = 3'b010,
        DSG_Z_C       = 3'b011,
        DSG_Z_CAS_SH  = 3'b100,
        DSG_Z_P_SH    = 3'b101
    } dsg_z_t;

    typedef enum logic [1:0] {
        DSG_W_ZERO  = 2'b00,
        DSG_W_P     = 2'b01,
        DSG_W_ROUND = 2'b10,
        DSG_W_C     = 2'b11
    } dsg_w_t;

    typedef enum logic [3:0] {
        DSG_CY_ZERO      = 4'b0000,
        DSG_CY_ONE       = 4'b0001,
        DSG_CY_EXT       = 4'b0010,
        DSG_CY_CAS_INF   = 4'b0011,
        DSG_CY_CAS_ZERO  = 4'b0100,
        DSG_CY_P_INF     = 4'b0101,
        DSG_CY_P_ZERO    = 4'b0110,
        DSG_CY_WIDE_PAR  = 4'b0111,
        DSG_CY_WIDE_SEQ  = 4'b1000,
        DSG_CY_ROUND_MUL = 4'b1001
    } dsg_carry_t;

    typedef struct packed {
        dsg_variant_t               variant_reg;
        dsg_opsel_t                 opsel_reg;
        logic [3:0]                 xy_reg;
        logic [2:0]                 z_reg;
        logic [3:0]                 alu_reg;
        logic [3:0]                 carry_reg;
        logic [1:0]                 w_reg;
        logic [3:0]                 paf_reg;
        logic                       pas_reg;
        logic                       mas_reg;
        logic                       mbs_reg;
        logic                       ast_reg;
        logic                       bst_reg;
        logic                       cin_meta_reg;
        logic                       cin_sync_reg;
        logic [21:0]                instr_reg;
        logic [4:0]                 width_reg;
        logic                       illegal_reg;
        logic                       waitreq_reg;
        logic [31:0]                rdata_reg;
    } dsg_state_t;

endpackage

/* File: design/dsg_instr_encode.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dsg_regs.svh"

module dsg_instr_encode
(
    input  wire dsg_pkg::dsg_variant_t  variant,
    input  wire dsg_pkg::dsg_opsel_t    opsel,
    input  wire logic [3:0]             xy,
    input  wire logic [2:0]             z,
    input  wire logic [3:0]             alu,
    input  wire logic [3:0]             carry,
    input  wire logic [1:0]             w,
    input  wire logic [3:0]             paf,
    input  wire logic                   pas,
    input  wire logic                   mas,
    input  wire logic                   mbs,
    input  wire logic                   ast,
    input  wire logic                   bst,
    input  wire logic                   cin_ext,
    output logic [21:0]                 word,
    output logic [4:0]                  width,
    output logic                        illegal
);
    import dsg_pkg::*;

    logic [3:0] xy_c;
    logic [2:0] z_c;
    logic [3:0] alu_c;
    logic [3:0] cy_c;

    always_comb
    begin
        xy_c    = DSG_XY_MUL;
        z_c     = DSG_Z_ZERO;
        alu_c   = `DSG_ALU_ADD;
        cy_c    = DSG_CY_ZERO;
        illegal = 1'b0;
        // presets ignore the custom fields except W, which the full variant always takes
        case (opsel) // (R9) (R10)
            DSG_OP_C_AB_MUL:   z_c = DSG_Z_C;
            DSG_OP_CAS_AB_MUL: z_c = DSG_Z_CASCADE;
            DSG_OP_P_AB_MUL:   z_c = DSG_Z_P;
            DSG_OP_AB_MUL:     z_c = DSG_Z_ZERO;
            DSG_OP_C_ADD_CAT:
            begin
                xy_c = DSG_XY_CAT;
                z_c  = DSG_Z_C;
            end
            DSG_OP_C_SUB_CAT:
            begin
                xy_c  = DSG_XY_CAT;
                z_c   = DSG_Z_C;
                alu_c = `DSG_ALU_SUB;
            end
            DSG_OP_C_ONLY:     xy_c = DSG_XY_C;
            DSG_OP_CUSTOM:
            begin
                xy_c  = xy;
                z_c   = z;
                alu_c = alu;
                cy_c  = carry;
            end
            default:           xy_c = DSG_XY_MUL;
        endcase
        // reserved codes fall back to zero sources and raise the flag
        if (xy_c > DSG_XY_CAT_C) // (R3) (R4)
        begin
            xy_c    = DSG_XY_ZERO;
            illegal = 1'b1;
        end
        if (z_c > DSG_Z_P_SH) // (R5) (R6)
        begin
            z_c     = DSG_Z_ZERO;
            illegal = 1'b1;
        end
        if (cy_c > DSG_CY_ROUND_MUL)
        begin
            cy_c    = DSG_CY_ZERO;
            illegal = 1'b1;
        end
        if (variant == DSG_VAR_RSVD)
            illegal = 1'b1;

        word = '0;
        word[`DSG_IW_XY_MSB:`DSG_IW_XY_LSB]   = xy_c;
        word[`DSG_IW_Z_MSB:`DSG_IW_Z_LSB]     = z_c;
        word[`DSG_IW_ALU_MSB:`DSG_IW_ALU_LSB] = alu_c; // (R2)
        case (cy_c) // (R8)
            DSG_CY_ZERO:
            begin
                word[`DSG_IW_CIN_BIT] = 1'b0;
                word[`DSG_IW_CSEL_MSB:`DSG_IW_CSEL_LSB] = `DSG_CSEL_FABRIC;
            end
            DSG_CY_ONE:
            begin
                word[`DSG_IW_CIN_BIT] = 1'b1;
                word[`DSG_IW_CSEL_MSB:`DSG_IW_CSEL_LSB] = `DSG_CSEL_FABRIC;
            end
            DSG_CY_EXT:
            begin
                word[`DSG_IW_CIN_BIT] = cin_ext;
                word[`DSG_IW_CSEL_MSB:`DSG_IW_CSEL_LSB] = `DSG_CSEL_FABRIC;
            end
            default:
                word[`DSG_IW_CSEL_MSB:`DSG_IW_CSEL_LSB] =
                    3'(cy_c - `DSG_CSEL_BASE);
        endcase

        width = `DSG_WIDTH_BASE;
        case (variant)
            DSG_VAR_MID:
            begin
                width = `DSG_WIDTH_MID;
                word[`DSG_IW_E1PA_MSB:`DSG_IW_E1PA_LSB] = paf;
                word[`DSG_IW_E1BS_BIT] = bst; // (R15)
            end
            DSG_VAR_FULL:
            begin
                width = `DSG_WIDTH_FULL;
                word[`DSG_IW_W_MSB:`DSG_IW_W_LSB] = w; // (R7)
                word[`DSG_IW_PAS_BIT] = pas; // (R11)
                word[`DSG_IW_MAS_BIT] = mas; // (R12)
                word[`DSG_IW_MBS_BIT] = mbs; // (R13)
                word[`DSG_IW_AST_BIT] = ast; // (R14)
                word[`DSG_IW_BST_BIT] = bst; // (R15)
            end
            default:
                width = `DSG_WIDTH_BASE;
        endcase
    end

endmodule

`default_nettype wire

/* File: tb/dsg_slice_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dsg_slice_model
(
    input  wire logic [21:0] instr_word,
    output logic [3:0]       alu_fn,
    output logic [2:0]       carry_sel
);
    // the slice decodes fields straight off the word, no decode delay
    assign alu_fn    = instr_word[10:7];
    assign carry_sel = instr_word[14:12];
endmodule
`default_nettype wire

/* File: tb/dsg_instr_gen_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module dsg_instr_gen_checker
(
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [21:0] instr_word,
    input wire logic [4:0]  instr_width,
    input wire logic        instr_illegal
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic commit;
    assign commit = avs_write && !avs_waitrequest;
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer after one wait");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without request");
    a_width_legal: assert property (
        instr_width inside {5'h0f, 5'h14, 5'h16})
        else $error("bad word width");
    a_base_zero: assert property (instr_width == 5'h0f
        |-> instr_word[21:15] == 7'h0) else $error("base word too wide");
    a_src_range: assert property (instr_word[3:0] <= 4'h6
        && instr_word[6:4] <= 3'h5) else $error("bad source code");
    // the carry bit may follow the pin, so it is left out here
    a_word_still: assert property ($changed({instr_word[21:12],
        instr_word[10:0], instr_width}) |-> $past(commit) || $past(commit, 2)
        || !$past(arst_n) || !$past(arst_n, 2))
        else $error("word moved without a write");
    a_rd_unmapped: assert property (avs_read && !avs_waitrequest
        && avs_address > 3'h4 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    c_write: cover property (commit);
    c_illegal: cover property (instr_illegal);
    c_full: cover property (instr_width == 5'h16);
endmodule
bind dsg_instr_gen dsg_instr_gen_checker u_dsg_instr_gen_checker
(
    .ref_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .instr_word, .instr_width, .instr_illegal
);
`default_nettype wire

/* File: tb/test_dsg_instr_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module test_dsg_instr_gen;
    import dsg_pkg::*;
    logic        ref_clk;
    logic        arst_n;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        carry_in;
    logic [21:0] instr_word;
    logic [4:0]  instr_width;
    logic        instr_illegal;
    logic [3:0]  m_alu;
    logic [2:0]  m_csel;
    logic [31:0] q;
    int          err_total;
    int          cmp_count;

    dsg_instr_gen u_dsg_instr_gen
    (
        .ref_clk, .arst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .carry_in,
        .instr_word, .instr_width, .instr_illegal
    );
    dsg_slice_model u_dsg_slice_model
    (
        .instr_word, .alu_fn(m_alu), .carry_sel(m_csel)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request stays up until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [2:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            err_total++;
            $display("[FAIL] %0t bus timeout", $time);
            complete_run();
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    // word follows a config write one edge late; three give margin
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        arst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        settle();
        chk(instr_word, 32'h33);
        chk(instr_width, 32'h0f);
        chk(instr_illegal, 32'h0);
        rd(3'h0, 32'h0);
        rd(3'h1, 32'h0);
        rd(3'h2, 32'h0);
        rd(3'h7, 32'h0);
        rd(3'h4, 32'h0f00);
    endtask

    task automatic t_presets();
        logic [21:0] e [7];
        e = '{22'h33, 22'h13, 22'h23, 22'h03, 22'h32, 22'h1b2, 22'h04};
        wr(3'h1, 32'h3_5154);
        for (int i = 0; i < 7; i++)
        begin
            wr(3'h0, i << 4);
            settle();
            chk(instr_word, e[i]);
            chk(m_alu, i == 5 ? 3 : 0);
        end
    endtask

    task automatic t_custom();
        wr(3'h0, 32'h72);
        wr(3'h2, 32'h1f0);
        for (int w = 0; w < 4; w++)
        begin
            wr(3'h1, 32'h342 | w << 16);
            settle();
            chk(instr_word, 32'h3e01c2 | w << 15);
        end
        chk(instr_width, 32'h16);
        for (int b = 0; b < 5; b++)
        begin
            wr(3'h2, 32'h10 << b);
            settle();
            chk(instr_word, 32'h181c2 | 1 << 17 + b);
        end
        for (int k = 0; k < 7; k++)
        begin
            wr(3'h1, k | (k % 6) << 4);
            settle();
            chk(instr_word[6:0], k | (k % 6) << 4);
        end
        carry_in <= 1'b1;
        for (int c = 0; c < 10; c++)
        begin
            wr(3'h1, c << 12);
            settle();
            chk(m_csel, c < 3 ? 0 : c - 2);
            if (c < 3)
                chk(instr_word[11], c != 0);
        end
        wr(3'h1, 32'h2000);
        carry_in <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk(instr_word[11], 32'h0);
        carry_in <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(instr_word[11], 32'h1);
    endtask

    task automatic t_mid();
        wr(3'h0, 32'h1);
        wr(3'h2, 32'h185);
        settle();
        chk(instr_word, 32'ha8033);
        chk(instr_width, 32'h14);
        wr(3'h0, 32'h0);
        settle();
        chk(instr_word, 32'h33);
    endtask

    task automatic t_illegal();
        wr(3'h0, 32'h3);
        settle();
        chk(instr_illegal, 32'h1);
        wr(3'h0, 32'h72);
        wr(3'h1, 32'h7);
        settle();
        chk(instr_illegal, 32'h1);
        chk(instr_word, 32'h300000);
        wr(3'h1, 32'hf070);
        settle();
        chk(instr_word, 32'h300000);
        rd(3'h4, 32'h1601);
        wr(3'h3, 32'h3fffff);
        repeat (20) @(posedge ref_clk);
        rd(3'h3, 32'h300000);
    endtask

    initial
    begin
        err_total     = 0;
        cmp_count     = 0;
        arst_n        = 1'b0;
        avs_address   = 3'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        carry_in      = 1'b0;
        t_reset();
        t_presets();
        t_custom();
        t_mid();
        t_illegal();
        t_reset();
        complete_run();
    end
endmodule
`default_nettype wire
